// *** design/touch_qual.sv ***
// Purpose: touch blocking and multiple-touch pattern detection
// Assumes: cycle_done_i pulses once when all inputs hold averaged deltas
// Notes:   all inputs come from logic on clk_i, so none are synchronised
`timescale 1ns/100ps
`default_nettype none

// Operation
// - block enable clear: every detected touch is reported unblocked
// - block enable set (reset): flag up to limit, hold until release
// - after a release, refill accepted touches in order input 1 to 3
// - touches beyond the limit set the touch overflow flag
// - limit field bits 3:2 decode 00=1, 01=2, 10=3, 11=3
// - blocking compares deltas against the full touch or standby threshold
// - pattern threshold is 12.5, 25, 37.5 or 100 percent of reference
// - reference is the touch threshold, or standby threshold in standby
// - compare mode 1: all selected inputs hit or noisy sets the event
// - compare mode 0: hit count at least number of select bits
// - pattern condition uses the results of one polling cycle only
// - a pattern event blocks every touch and raises an alert indication
// - inputs stay blocked while the condition persists, then recover
// - event flag clears only on host clear after condition is gone
// - pattern detection runs only while bit 7 enable is set
// - alert enable bit 0 gates the alert pin, flag is set anyway
// - select bits 2:0 map inputs 3..1, reset value 07h
module touch_qual
(
	input  wire logic                          clk_i,
	input  wire logic                          rst_i,
	input  wire touch_qual_pkg::reg_req_type   reg_req_i,
	output logic [7:0]                         reg_rdata_o,
	input  wire touch_qual_pkg::sense_in_type  sense_i,
	input  wire logic                          cycle_done_i,
	input  wire logic                          event_clear_i,
	output logic [2:0]                         touch_status_o,
	output logic                               touch_overflow_flag_o,
	output logic                               pattern_event_flag_o,
	output logic                               alert_n_o
);
	import touch_qual_pkg::*;

	typedef struct packed {
		logic [7:0] touch_block_config;
		logic [7:0] pattern_detect_config;
		logic [7:0] pattern_select;
		logic [2:0] accepted;
		logic       touch_overflow_flag;
		logic       condition;
		logic       pattern_event_flag;
		logic       alert_n;
		logic [7:0] rdata;
	} state_type;

	state_type s_q;
	state_type s_d;

	// decoded control fields
	logic       many_touch_block_enable;
	logic [1:0] simul_touch_limit;
	logic       pattern_detect_enable;
	logic [1:0] pattern_threshold_select;
	logic       pattern_compare_mode;
	logic       pattern_alert_enable;
	logic [2:0] pattern_sel;

	assign many_touch_block_enable  = s_q.touch_block_config[BIT_BLOCK_EN];
	assign simul_touch_limit        =
		limit_decode(s_q.touch_block_config[POS_LIMIT +: 2]);
	assign pattern_detect_enable    =
		s_q.pattern_detect_config[BIT_PATTERN_EN];
	assign pattern_threshold_select =
		s_q.pattern_detect_config[POS_PTH_SEL +: 2];
	assign pattern_compare_mode     =
		s_q.pattern_detect_config[BIT_COMPARE_MODE];
	assign pattern_alert_enable     = s_q.pattern_detect_config[BIT_ALERT_EN];
	assign pattern_sel              = s_q.pattern_select[2:0];

	// per-input compare against full and reduced thresholds
	logic [3:0]  pth_eighths;
	logic [2:0]  raw_touch;
	logic [2:0]  pattern_hit;

	always_comb
	begin
		case (pattern_threshold_select)
			2'b00:   pth_eighths = PTH_EIGHTHS_0;
			2'b01:   pth_eighths = PTH_EIGHTHS_1;
			2'b10:   pth_eighths = PTH_EIGHTHS_2;
			default: pth_eighths = PTH_EIGHTHS_3;
		endcase
	end

	genvar gi;
	generate
		for (gi = 0; gi < NUM_INPUTS; gi++)
		begin : g_in
			logic [THRESH_W-1:0] ref_th;
			logic [10:0]         scaled;
			// standby uses its own reference
			assign ref_th = sense_i.standby ? sense_i.standby_th
				: sense_i.touch_th[gi];
			assign scaled = {4'h0, ref_th} * {7'h00, pth_eighths};
			// full threshold for blocking, scaled one for patterns
			assign raw_touch[gi] =
				sense_i.delta[gi] > {1'b0, ref_th};
			assign pattern_hit[gi] = (sense_i.delta[gi] > scaled[10:3])
				| sense_i.noise[gi];
		end
	endgenerate

	// pattern condition from this cycle's results only
	logic pattern_match;

	always_comb
	begin
		if (pattern_sel == 3'b000)
			pattern_match = 1'b0; // empty pattern never fires
		else if (pattern_compare_mode)
			pattern_match =
				(pattern_hit & pattern_sel) == pattern_sel;
		else
			pattern_match =
				count3(pattern_hit) >= count3(pattern_sel);
	end

	logic cond_now;
	assign cond_now =
		pattern_detect_enable & pattern_match;

	// accepted set: keep held inputs, then fill in input order
	logic [2:0] keep;
	logic [2:0] fill;
	logic [1:0] room;

	// a lowered limit trims held touches too, so the limit always holds
	always_comb
	begin
		keep = s_q.accepted & raw_touch; // released inputs drop out
		fill = 3'b000;
		room = 2'd0;
		for (int i = 0; i < NUM_INPUTS; i++)
		begin
			room = count3(fill);
			if (keep[i] && room < simul_touch_limit)
				fill[i] = 1'b1; // held touches keep their slot
		end
		for (int i = 0; i < NUM_INPUTS; i++)
		begin
			room = count3(fill);
			if (raw_touch[i] && !fill[i] && room < simul_touch_limit)
				fill[i] = 1'b1; // lowest input wins a free slot
		end
	end

	// next-state: registers, decisions, read data
	always_comb
	begin
		s_d = s_q;
		if (reg_req_i.wr)
		begin
			case (reg_req_i.addr)
				OFS_TOUCH_BLOCK:
					s_d.touch_block_config = reg_req_i.wdata & MSK_TOUCH_BLOCK;
				OFS_PATTERN_CFG:
					s_d.pattern_detect_config =
						reg_req_i.wdata & MSK_PATTERN_CFG;
				OFS_PATTERN_SEL:
					s_d.pattern_select = reg_req_i.wdata & MSK_PATTERN_SEL;
				default: ;
			endcase
		end
		case (reg_req_i.addr)
			OFS_TOUCH_BLOCK: s_d.rdata = s_q.touch_block_config;
			OFS_PATTERN_CFG: s_d.rdata = s_q.pattern_detect_config;
			OFS_PATTERN_SEL: s_d.rdata = s_q.pattern_select;
			default:         s_d.rdata = 8'h00;
		endcase
		// host clear honoured only once the condition has gone
		if (event_clear_i && !s_q.condition)
			s_d.pattern_event_flag = 1'b0;
		if (cycle_done_i)
		begin
			s_d.condition = cond_now;
			if (cond_now)
			begin
				s_d.accepted            = 3'b000;
				s_d.touch_overflow_flag = 1'b0;
				s_d.pattern_event_flag  = 1'b1; // set beats clear
			end
			else if (!many_touch_block_enable)
			begin
				s_d.accepted            = raw_touch;
				s_d.touch_overflow_flag = 1'b0;
			end
			else
			begin
				s_d.accepted            = fill;
				s_d.touch_overflow_flag =
					(raw_touch & ~fill) != 3'b000;
			end
		end
		// alert pin follows the flag only when enabled; the next enable is
		// used so a write that drops the enable also releases the pin
		s_d.alert_n = ~(s_d.pattern_event_flag
			& s_d.pattern_detect_config[BIT_ALERT_EN]);
	end

	// reset image, built once so the register gets one assignment per edge
	localparam state_type S_RESET = '{
		touch_block_config:    RST_TOUCH_BLOCK,
		pattern_detect_config: RST_PATTERN_CFG,
		pattern_select:        RST_PATTERN_SEL,
		alert_n:               1'b1,
		default:               '0
	};

	// single state register
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			s_q <= S_RESET;
		else
			s_q <= s_d;
	end

	assign reg_rdata_o           = s_q.rdata;
	assign touch_status_o        = s_q.accepted;
	assign touch_overflow_flag_o = s_q.touch_overflow_flag;
	assign pattern_event_flag_o  = s_q.pattern_event_flag;
	assign alert_n_o             = s_q.alert_n;

	// checks on the decisions; reset gates all but the reset-value check
	a_block_off_pass: assert property (
		@(posedge clk_i) disable iff (rst_i)
		cycle_done_i && !many_touch_block_enable && !cond_now
		|=> touch_status_o == $past(raw_touch))
		else $error("touches not passed through with blocking off");

	a_limit_held: assert property (
		@(posedge clk_i) disable iff (rst_i)
		cycle_done_i && many_touch_block_enable
		|=> count3(touch_status_o) <= $past(simul_touch_limit))
		else $error("more touches flagged than the limit");

	a_accept_keep: assert property (
		@(posedge clk_i) disable iff (rst_i)
		cycle_done_i && many_touch_block_enable && !cond_now
		&& count3(keep) <= simul_touch_limit
		|=> (touch_status_o & $past(keep)) == $past(keep))
		else $error("held touch dropped while still touched");

	a_order_fill: assert property (
		@(posedge clk_i) disable iff (rst_i)
		cycle_done_i && many_touch_block_enable && !cond_now
		&& s_q.accepted == 3'b000 && raw_touch == 3'b111
		&& simul_touch_limit == 2'd1
		|=> touch_status_o == 3'b001)
		else $error("free slot not given to the lowest input");

	a_overflow_set: assert property (
		@(posedge clk_i) disable iff (rst_i)
		cycle_done_i && many_touch_block_enable && !cond_now
		&& count3(raw_touch) > simul_touch_limit
		|=> touch_overflow_flag_o)
		else $error("overflow flag missed");

	a_no_overflow: assert property (
		@(posedge clk_i) disable iff (rst_i)
		cycle_done_i && many_touch_block_enable && !cond_now
		&& count3(raw_touch) <= simul_touch_limit
		|=> !touch_overflow_flag_o)
		else $error("overflow flag set with touches inside the limit");

	a_full_thresh: assert property (
		@(posedge clk_i) disable iff (rst_i)
		cycle_done_i |=> (touch_status_o & ~$past(raw_touch)) == 3'b000)
		else $error("touch flagged below the full threshold");

	a_mode_match: assert property (
		@(posedge clk_i) disable iff (rst_i)
		cycle_done_i && pattern_detect_enable && pattern_compare_mode
		&& pattern_sel != 3'b000 && (pattern_hit & pattern_sel) == pattern_sel
		|=> pattern_event_flag_o)
		else $error("matching pattern not flagged");

	a_mode_count: assert property (
		@(posedge clk_i) disable iff (rst_i)
		cycle_done_i && pattern_detect_enable && !pattern_compare_mode
		&& pattern_sel != 3'b000
		&& count3(pattern_hit) >= count3(pattern_sel)
		|=> pattern_event_flag_o)
		else $error("enough pattern hits not flagged");

	a_pattern_block: assert property (
		@(posedge clk_i) disable iff (rst_i)
		cycle_done_i && cond_now
		|=> touch_status_o == 3'b000 && pattern_event_flag_o)
		else $error("pattern event did not block and flag");

	a_touch_recover: assert property (
		@(posedge clk_i) disable iff (rst_i)
		cycle_done_i && s_q.condition && !cond_now && raw_touch != 3'b000
		|=> touch_status_o != 3'b000)
		else $error("touch detection not restored after pattern");

	a_event_hold: assert property (
		@(posedge clk_i) disable iff (rst_i)
		pattern_event_flag_o && s_q.condition && !cycle_done_i
		|=> pattern_event_flag_o)
		else $error("event flag cleared while condition present");

	a_clear_works: assert property (
		@(posedge clk_i) disable iff (rst_i)
		event_clear_i && !s_q.condition && !cycle_done_i
		|=> !pattern_event_flag_o)
		else $error("host clear ignored after condition gone");

	a_detect_off: assert property (
		@(posedge clk_i) disable iff (rst_i)
		cycle_done_i && !pattern_detect_enable |=> !s_q.condition)
		else $error("pattern detected while disabled");

	a_alert_gate: assert property (
		@(posedge clk_i) disable iff (rst_i)
		!alert_n_o |-> pattern_event_flag_o && pattern_alert_enable)
		else $error("alert asserted without flag or enable");

	a_alert_follow: assert property (
		@(posedge clk_i) disable iff (rst_i)
		alert_n_o == !(pattern_event_flag_o && pattern_alert_enable))
		else $error("alert pin does not follow flag and enable");

	a_reset_sel: assert property (
		@(posedge clk_i)
		$fell(rst_i) |-> s_q.pattern_select == RST_PATTERN_SEL
		&& s_q.touch_block_config == RST_TOUCH_BLOCK)
		else $error("register reset value wrong");

	a_hold_between: assert property (
		@(posedge clk_i) disable iff (rst_i)
		!cycle_done_i |=> $stable(touch_status_o)
		&& $stable(touch_overflow_flag_o))
		else $error("decision changed between polling cycles");

	c_overflow: cover property (@(posedge clk_i) disable iff (rst_i)
		$rose(touch_overflow_flag_o));
	c_event_alert: cover property (@(posedge clk_i) disable iff (rst_i)
		$fell(alert_n_o));
	c_event_cleared: cover property (@(posedge clk_i) disable iff (rst_i)
		$fell(pattern_event_flag_o));
	c_match_event: cover property (@(posedge clk_i) disable iff (rst_i)
		cycle_done_i && cond_now && pattern_compare_mode);
	c_clear_refused: cover property (@(posedge clk_i) disable iff (rst_i)
		event_clear_i && s_q.condition);

endmodule : touch_qual

`default_nettype wire

// *** design/touch_qual_pkg.sv ***
// Purpose: shared constants, types and helpers for touch qualification
// Assumes: three sense inputs, 8-bit registers, one polling cycle strobe
// Notes:   field positions and reset values are named here only once
package touch_qual_pkg;

	localparam int          NUM_INPUTS       = 3;
	localparam int          DELTA_W          = 8;
	localparam int          THRESH_W         = 7;

	// register offsets
	localparam logic [7:0]  OFS_TOUCH_BLOCK  = 8'h2a;
	localparam logic [7:0]  OFS_PATTERN_CFG  = 8'h2b;
	localparam logic [7:0]  OFS_PATTERN_SEL  = 8'h2d;

	// reset values
	localparam logic [7:0]  RST_TOUCH_BLOCK  = 8'h80;
	localparam logic [7:0]  RST_PATTERN_CFG  = 8'h00;
	localparam logic [7:0]  RST_PATTERN_SEL  = 8'h07;

	// writable bits, reserved bits read as zero
	localparam logic [7:0]  MSK_TOUCH_BLOCK  = 8'h8c;
	localparam logic [7:0]  MSK_PATTERN_CFG  = 8'h8f;
	localparam logic [7:0]  MSK_PATTERN_SEL  = 8'h07;

	// field positions
	localparam int          BIT_BLOCK_EN     = 7;
	localparam int          POS_LIMIT        = 2;
	localparam int          BIT_PATTERN_EN   = 7;
	localparam int          POS_PTH_SEL      = 2;
	localparam int          BIT_COMPARE_MODE = 1;
	localparam int          BIT_ALERT_EN     = 0;

	// pattern threshold in eighths of the reference: 12.5/25/37.5/100 %
	localparam logic [3:0]  PTH_EIGHTHS_0    = 4'h1;
	localparam logic [3:0]  PTH_EIGHTHS_1    = 4'h2;
	localparam logic [3:0]  PTH_EIGHTHS_2    = 4'h3;
	localparam logic [3:0]  PTH_EIGHTHS_3    = 4'h8;

	// per-input results of one polling cycle
	typedef struct packed {
		logic [NUM_INPUTS-1:0][DELTA_W-1:0]  delta;
		logic [NUM_INPUTS-1:0][THRESH_W-1:0] touch_th;
		logic [THRESH_W-1:0]                 standby_th;
		logic [NUM_INPUTS-1:0]               noise;
		logic                                standby;
	} sense_in_type;

	// register port request
	typedef struct packed {
		logic [7:0] addr;
		logic       wr;
		logic [7:0] wdata;
	} reg_req_type;

	// number of set bits among the three inputs
	function automatic logic [1:0] count3(input logic [2:0] v);
		count3 = {1'b0, v[0]} + {1'b0, v[1]} + {1'b0, v[2]};
	endfunction : count3

	// simultaneous-touch limit decode: 00->1, 01->2, 1x->3
	function automatic logic [1:0] limit_decode(input logic [1:0] f);
		limit_decode = (f == 2'b00) ? 2'd1 : ((f == 2'b01) ? 2'd2 : 2'd3);
	endfunction : limit_decode

endpackage : touch_qual_pkg

// *** verification/touch_host_model.sv ***
// Purpose: host side that clears the pattern event flag
// Assumes: bench raises clear_req_i for one cycle
// Notes:   asks whenever told, so refused clears can be seen
`timescale 1ns/100ps
`default_nettype none
module touch_host_model
(
	input  wire logic clk_i,
	input  wire logic clear_req_i,
	output logic      event_clear_o
);
	// one-cycle clear pulse after the request edge
	always_ff @(posedge clk_i)
		event_clear_o <= clear_req_i;
endmodule : touch_host_model
`default_nettype wire

// *** verification/touch_qual_tb.sv ***
// Purpose: random and directed test of touch qualification
// Assumes: results one cycle after cycle_done or address
// Notes:   a small reference model predicts every poll
`timescale 1ns/100ps
`default_nettype none
module touch_qual_tb;
	import touch_qual_pkg::*;
	logic         clk_i, rst_i, cycle_done_i, clear_req, event_clear_i;
	logic         rd_mark, p1, flag_m, cond_m, ovf_m, touch_overflow_flag_o;
	logic         pattern_event_flag_o, alert_n_o;
	reg_req_type  reg_req_i;
	sense_in_type sense_i;
	logic [7:0]   reg_rdata_o, cfg_b, cfg_p, sel;
	logic [6:0]   sth;
	logic [2:0]   touch_status_o, acc_m, raw, hit, nacc;
	logic [8:0]   exp_q[$];
	logic [8:0]   e;
	int           num_errors, total_checks, seed, k[4];

	touch_qual dut (.clk_i(clk_i), .rst_i(rst_i), .reg_req_i(reg_req_i),
		.reg_rdata_o(reg_rdata_o), .sense_i(sense_i),
		.cycle_done_i(cycle_done_i), .event_clear_i(event_clear_i),
		.touch_status_o(touch_status_o),
		.touch_overflow_flag_o(touch_overflow_flag_o),
		.pattern_event_flag_o(pattern_event_flag_o), .alert_n_o(alert_n_o));
	touch_host_model host (.clk_i(clk_i), .clear_req_i(clear_req),
		.event_clear_o(event_clear_i));

	function automatic int ones(input logic [2:0] v);
		return int'(v[0]) + int'(v[1]) + int'(v[2]);
	endfunction : ones

	task automatic check(input logic [7:0] seen, input logic [7:0] want);
		total_checks++;
		if (seen !== want)
		begin
			num_errors++;
			$display("[FAIL] t=%0t seen=%h want=%h", $time, seen, want);
		end
	endtask : check

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		reg_req_i <= '{a, 1'b1, d};
		// shadow keeps only the writable bits
		if (a == 8'h2a)
			cfg_b = d & 8'h8c;
		if (a == 8'h2b)
			cfg_p = d & 8'h8f;
		if (a == 8'h2d)
			sel = d & 8'h07;
		@(posedge clk_i);
		reg_req_i.wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [7:0] want);
		@(posedge clk_i);
		reg_req_i <= '{a, 1'b0, 8'h00};
		rd_mark <= 1'b1;
		exp_q.push_back({1'b1, want});
		@(posedge clk_i);
		rd_mark <= 1'b0;
	endtask : rd

	// one polling cycle of random deltas, thresholds and noise
	task automatic poll();
		logic [7:0] d[3];
		logic [6:0] th[3];
		logic [2:0] nz;
		logic       sb;
		int         rv, lim;
		nz = 3'($random(seed) & $random(seed) & $random(seed));
		sb = 1'($random(seed));
		sth = 7'($random(seed));
		lim = (cfg_b[3:2] == 2'h0) ? 1
			: ((cfg_b[3:2] == 2'h1) ? 2 : 3);
		for (int i = 0; i < 3; i++)
		begin
			d[i] = 8'($random(seed));
			th[i] = 7'($random(seed));
			rv = sb ? int'(sth) : int'(th[i]);
			raw[i] = int'(d[i]) > rv;
			hit[i] = nz[i]
				|| int'(d[i]) > ((rv * k[cfg_p[3:2]]) >> 3);
		end
		cond_m = cfg_p[7] && sel[2:0] != 3'h0 && (cfg_p[1]
			? (hit & sel[2:0]) == sel[2:0]
			: ones(hit) >= ones(sel[2:0]));
		ovf_m = 1'b0;
		if (cond_m)
		begin
			acc_m = 3'h0;
			flag_m = 1'b1;
		end
		else if (!cfg_b[7])
			acc_m = raw;
		else
		begin
			// held touches first, trimmed to a lowered limit, then free slots
			nacc = 3'h0;
			for (int i = 0; i < 3; i++)
				if (acc_m[i] && raw[i] && ones(nacc) < lim)
					nacc[i] = 1'b1;
			for (int i = 0; i < 3; i++)
				if (raw[i] && ones(nacc) < lim)
					nacc[i] = 1'b1;
			ovf_m = |(raw & ~nacc);
			acc_m = nacc;
		end
		@(posedge clk_i);
		sense_i <= {d[2], d[1], d[0], th[2], th[1], th[0], sth, nz, sb};
		cycle_done_i <= 1'b1;
		exp_q.push_back({3'h0, acc_m, ovf_m, flag_m, !(flag_m && cfg_p[0])});
		@(posedge clk_i);
		cycle_done_i <= 1'b0;
	endtask : poll

	// host clear, refused while the last condition still held
	task automatic clr();
		@(posedge clk_i);
		clear_req <= 1'b1;
		@(posedge clk_i);
		clear_req <= 1'b0;
		@(posedge clk_i);
		if (!cond_m)
			flag_m = 1'b0;
	endtask : clr

	task automatic close_out();
		$display("checks=%0d errors=%0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : close_out

	// compare what appears two edges after each request
	always @(posedge clk_i)
	begin
		if (p1)
		begin
			e = exp_q.pop_front();
			if (e[8])
				check(reg_rdata_o, e[7:0]);
			else
			begin
				check({5'h0, touch_status_o},
					{5'h0, e[5:3]});
				check({7'h0, touch_overflow_flag_o}, {7'h0, e[2]});
				check({6'h0, pattern_event_flag_o, alert_n_o},
					{6'h0, e[1:0]});
			end
		end
		p1 <= cycle_done_i | rd_mark;
	end

	initial
	begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end

	// hang guard, far beyond the normal run
	initial
	begin
		#400000;
		num_errors++;
		close_out();
	end

	initial
	begin
		{cycle_done_i, clear_req, rd_mark, p1, flag_m, cond_m} = 6'h0;
		reg_req_i = '0;
		sense_i = '0;
		k = '{1, 2, 3, 8};
		acc_m = 3'h0;
		{cfg_b, cfg_p, sel} = 24'h800007;
		seed = 32'h01ea;
		rst_i = 1'b1;
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(8'h2a, 8'h80);
		rd(8'h2b, 8'h00);
		rd(8'h2d, 8'h07);
		rd(8'h2c, 8'h00);
		wr(8'h2b, 8'hff);
		rd(8'h2b, 8'h8f);
		wr(8'h2c, 8'hff);
		rd(8'h2c, 8'h00);
		$display("register test done");
		// random configs cover every mode, limit and threshold code
		repeat (60)
		begin
			wr(8'h2a, 8'($random(seed)));
			wr(8'h2b, 8'($random(seed)));
			wr(8'h2d, 8'($random(seed)));
			repeat (5) poll();
			clr();
			poll();
			rd(8'h2a, cfg_b);
		end
		$display("random test done");
		close_out();
	end
endmodule : touch_qual_tb
`default_nettype wire
